// *** core/sli_flash.sv ***
module sli_flash #(
   parameter int HOLD_CYC = sli_pkg::FLASH_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Activity pulse, already synchronous
   input wire logic act,
   // Flashing LED drive
   output logic led
);
   logic [31:0] cnt_q, cnt_d;
   logic led_q, led_d;

   // Toggle and reload on activity once the hold has run out; drive low when idle
   always_comb begin
      cnt_d = cnt_q;
      led_d = led_q;
      if (cnt_q != 32'h0) begin
         cnt_d = cnt_q - 32'h1;
      end else if (act) begin
         cnt_d = 32'(HOLD_CYC);
         led_d = ~led_q;
      end else begin
         led_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_q <= 32'h0;
         led_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         led_q <= led_d;
      end
   end

   assign led = led_q;
endmodule

// *** core/sli_pkg.sv ***
package sli_pkg;
   // ****************************************
   // Run modes
   // ****************************************
   typedef enum logic [1:0] {
      SLI_MODE_OFFLINE,
      SLI_MODE_STOP,
      SLI_MODE_RUN,
      SLI_MODE_CONFIG
   } sli_mode_t;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 250;
   localparam int FAST_HALF_US = 50000;
   localparam int SLOW_HALF_US = 200000;
   localparam int GAP_US = 1000000;
   localparam int FLASH_US = 50000;
   localparam int FAST_HALF_CYC = FAST_HALF_US * CLK_MHZ;
   localparam int SLOW_HALF_CYC = SLOW_HALF_US * CLK_MHZ;
   localparam int GAP_CYC = GAP_US * CLK_MHZ;
   localparam int FLASH_CYC = FLASH_US * CLK_MHZ;
   localparam int FAST_PULSES = 8;

   // ****************************************
   // Error codes
   // ****************************************
   localparam logic [3:0] ERR_FORMAT = 4'hE;
   localparam logic [3:0] ERR_CHECKSUM = 4'h9;
   localparam logic [7:0] ARG_NONE = 8'h00;
endpackage

// *** core/sli_top.sv ***
// Contract
// - run LED red stop, green run, blue config
// - green link/activity LED per port
// - expansion LED flashes on traffic
// - bus LED off, flash green, red error
// - storage LED red during card access
// - fast burst, code pulses, argument pulses
// - runs from reset with no start command
// - wrong format gives code 14, position argument
// - program checksum gives code 9, argument 0
module sli_top #(
   parameter int FAST_HALF = sli_pkg::FAST_HALF_CYC,
   parameter int SLOW_HALF = sli_pkg::SLOW_HALF_CYC,
   parameter int GAP = sli_pkg::GAP_CYC,
   parameter int FLASH = sli_pkg::FLASH_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Status inputs, asynchronous
   input wire logic [1:0] run_mode,
   input wire logic port1_link,
   input wire logic port1_act,
   input wire logic port2_link,
   input wire logic port2_act,
   input wire logic exp_act,
   input wire logic tbus_active,
   input wire logic tbus_act,
   input wire logic card_busy,
   input wire logic err_format,
   input wire logic err_checksum,
   input wire logic [7:0] err_position,
   // LED drives
   output logic [2:0] run_state_led,
   output logic first_port_led,
   output logic second_port_led,
   output logic exp_led,
   output logic tbus_green_led,
   output logic tbus_red_led,
   output logic storage_access_led
);
   // ****************************************
   // Input synchronisers
   // ****************************************
   localparam int NIN = 20;
   logic [NIN-1:0] raw, s1_q, s2_q;
   assign raw = {run_mode, port1_link, port1_act, port2_link, port2_act, exp_act,
                 tbus_active, tbus_act, card_busy, err_format, err_checksum, err_position};
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end
   logic [1:0] mode_s;
   logic p1l, p1a, p2l, p2a, exa, tba, tbt, cbs, efm, eck;
   logic [7:0] pos_s;
   assign {mode_s, p1l, p1a, p2l, p2a, exa, tba, tbt, cbs, efm, eck, pos_s} = s2_q;

   // ****************************************
   // Activity flashers
   // ****************************************
   logic p1_fl, p2_fl, ex_fl, tb_fl;
   sli_flash #(.HOLD_CYC(FLASH)) u_p1 (.clk(clk), .rstn(rstn), .act(p1a), .led(p1_fl));
   sli_flash #(.HOLD_CYC(FLASH)) u_p2 (.clk(clk), .rstn(rstn), .act(p2a), .led(p2_fl));
   sli_flash #(.HOLD_CYC(FLASH)) u_ex (.clk(clk), .rstn(rstn), .act(exa), .led(ex_fl));
   sli_flash #(.HOLD_CYC(FLASH)) u_tb (.clk(clk), .rstn(rstn), .act(tbt), .led(tb_fl));

   // ****************************************
   // Blink code sequencer
   // ****************************************
   typedef enum logic [2:0] {S_IDLE, S_FAST, S_CODE, S_MID, S_ARG, S_GAP} sli_state_t;
   sli_state_t st_q, st_d;
   logic [31:0] tmr_q, tmr_d;
   logic [7:0] left_q, left_d;
   logic on_q, on_d;
   logic [3:0] code_q, code_d;
   logic [7:0] arg_q, arg_d;
   logic err_now;
   assign err_now = efm | eck;

   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      left_d = left_q;
      on_d = on_q;
      code_d = code_q;
      arg_d = arg_q;
      if (tmr_q != 32'h0) begin
         tmr_d = tmr_q - 32'h1;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               if (err_now) begin
                  // Format error has priority over checksum
                  code_d = efm ? sli_pkg::ERR_FORMAT : sli_pkg::ERR_CHECKSUM;
                  arg_d = efm ? pos_s : sli_pkg::ARG_NONE;
                  st_d = S_FAST;
                  left_d = 8'(sli_pkg::FAST_PULSES);
                  on_d = 1'b1;
                  tmr_d = 32'(FAST_HALF);
               end
            end
            S_FAST, S_CODE, S_ARG: begin
               if (on_q) begin
                  on_d = 1'b0;
                  left_d = left_q - 8'h1;
                  tmr_d = 32'(st_q == S_FAST ? FAST_HALF : SLOW_HALF);
               end else if (left_q != 8'h0) begin
                  on_d = 1'b1;
                  tmr_d = 32'(st_q == S_FAST ? FAST_HALF : SLOW_HALF);
               end else if (st_q == S_FAST) begin
                  st_d = S_MID;
                  tmr_d = 32'(SLOW_HALF);
               end else if (st_q == S_CODE) begin
                  st_d = S_MID;
                  tmr_d = 32'(SLOW_HALF);
               end else begin
                  st_d = S_GAP;
                  tmr_d = 32'(GAP);
               end
            end
            S_MID: begin
               // Pause before the code run, then before the argument run
               if (code_q != 4'h0) begin
                  st_d = S_CODE;
                  left_d = {4'h0, code_q};
                  code_d = 4'h0;
                  on_d = 1'b1;
                  tmr_d = 32'(SLOW_HALF);
               end else if (arg_q != 8'h0) begin
                  st_d = S_ARG;
                  left_d = arg_q;
                  on_d = 1'b1;
                  tmr_d = 32'(SLOW_HALF);
               end else begin
                  st_d = S_GAP;
                  tmr_d = 32'(GAP);
               end
            end
            S_GAP: begin
               st_d = S_IDLE;
            end
            default: begin
               st_d = S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_q <= S_IDLE;
         tmr_q <= 32'h0;
         left_q <= 8'h0;
         on_q <= 1'b0;
         code_q <= 4'h0;
         arg_q <= 8'h0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         left_q <= left_d;
         on_q <= on_d;
         code_q <= code_d;
         arg_q <= arg_d;
      end
   end

   // ****************************************
   // LED output registers
   // ****************************************
   logic [2:0] run_d;
   logic red_d;
   always_comb begin
      unique case (sli_pkg::sli_mode_t'(mode_s))
         sli_pkg::SLI_MODE_OFFLINE: run_d = 3'h0;
         sli_pkg::SLI_MODE_STOP: run_d = 3'h4;
         sli_pkg::SLI_MODE_RUN: run_d = 3'h2;
         sli_pkg::SLI_MODE_CONFIG: run_d = 3'h1;
      endcase
      red_d = (st_q == S_IDLE) ? err_now : on_q;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         run_state_led <= 3'h0;
         first_port_led <= 1'b0;
         second_port_led <= 1'b0;
         exp_led <= 1'b0;
         tbus_green_led <= 1'b0;
         tbus_red_led <= 1'b0;
         storage_access_led <= 1'b0;
      end else begin
         run_state_led <= run_d;
         first_port_led <= p1l & ~p1_fl;
         second_port_led <= p2l & ~p2_fl;
         exp_led <= ex_fl;
         tbus_green_led <= tba & tb_fl & ~err_now & (st_q == S_IDLE);
         tbus_red_led <= red_d;
         storage_access_led <= cbs;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   a_run_offline: assert property (@(posedge clk) disable iff (!rstn)
      mode_s == 2'h0 |=> run_state_led == 3'h0) else $error("run LED lit offline");
   a_run_stop: assert property (@(posedge clk) disable iff (!rstn)
      mode_s == 2'h1 |=> run_state_led == 3'h4) else $error("run LED not red in stop");
   a_port_dark: assert property (@(posedge clk) disable iff (!rstn)
      !p1l |=> !first_port_led) else $error("port LED lit without link");
   a_exp_idle: assert property (@(posedge clk) disable iff (!rstn)
      !exa [*2] ##0 !ex_fl |=> !exp_led) else $error("expansion LED lit idle");
   a_tbus_colour: assert property (@(posedge clk) disable iff (!rstn)
      !(tbus_green_led && tbus_red_led)) else $error("bus LED both colours");
   a_store_led: assert property (@(posedge clk) disable iff (!rstn)
      cbs |=> storage_access_led) else $error("storage LED off during access");
   a_seq_start: assert property (@(posedge clk) disable iff (!rstn)
      st_q == S_IDLE && tmr_q == 32'h0 && err_now |=> st_q == S_FAST && on_q)
      else $error("burst did not start");
   a_code_fmt: assert property (@(posedge clk) disable iff (!rstn)
      st_q == S_IDLE && tmr_q == 32'h0 && efm |=> code_q == 4'hE && arg_q == $past(pos_s))
      else $error("format code wrong");
   a_code_sum: assert property (@(posedge clk) disable iff (!rstn)
      st_q == S_IDLE && tmr_q == 32'h0 && !efm && eck |=> code_q == 4'h9 && arg_q == 8'h0)
      else $error("checksum code wrong");
   a_gap_dark: assert property (@(posedge clk) disable iff (!rstn)
      st_q == S_GAP |=> !tbus_red_led) else $error("red lit in gap");
   c_err_seq: cover property (@(posedge clk) disable iff (!rstn) st_q == S_ARG);
   c_gap: cover property (@(posedge clk) disable iff (!rstn) st_q == S_GAP);
   c_green: cover property (@(posedge clk) disable iff (!rstn) tbus_green_led);
endmodule

// *** testbench/sli_panel.sv ***
module sli_panel #(
   parameter int FAST_MAX = 7,
   parameter int SLOW_MAX = 12
) (
   // Clock and control
   input wire logic clk,
   input wire logic arm,
   // Watched red bus LED
   input wire logic red,
   // Decoded blink code {fast, code, argument}
   output logic done,
   output logic [23:0] code
);
   timeunit 1ns;
   timeprecision 1ps;
   int hi;
   int lo;
   logic grp;
   logic [7:0] cf;
   logic [7:0] cc;
   logic [7:0] ca;
   // ****************************************
   // Operator eye
   // ****************************************
   // High length tells fast from slow; a long dark spell splits code from argument
   always @(posedge clk) begin
      done <= 1'b0;
      if (!arm) begin
         hi <= 0;
         lo <= 0;
         grp <= 1'b0;
         cf <= 8'h00;
         cc <= 8'h00;
         ca <= 8'h00;
      end else if (red) begin
         hi <= hi + 1;
         lo <= 0;
         if (lo > SLOW_MAX && cc != 8'h00) grp <= 1'b1;
      end else begin
         lo <= lo + 1;
         hi <= 0;
         if (hi > 0 && (hi <= FAST_MAX || hi > SLOW_MAX) && cc != 8'h00) begin
            done <= 1'b1;
            code <= {cf, cc, ca};
            cf <= (hi <= FAST_MAX) ? 8'h01 : 8'h00;
            cc <= 8'h00;
            ca <= 8'h00;
            grp <= 1'b0;
         end else if (hi > 0 && hi <= FAST_MAX) cf <= cf + 8'h01;
         else if (hi > SLOW_MAX) cf <= 8'h00;
         else if (hi > 0 && grp) ca <= ca + 8'h01;
         else if (hi > 0) cc <= cc + 8'h01;
      end
   end
endmodule

// *** testbench/test_status_led_indicator.sv ***
module test_status_led_indicator;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [1:0] kind; logic [23:0] v;} sli_note_t;
   logic clk = 1'b0;
   logic rstn, port1_link, port1_act, port2_link, port2_act, exp_act;
   logic tbus_active, tbus_act, card_busy, err_format, err_checksum;
   logic [1:0] run_mode;
   logic [7:0] err_position;
   logic [2:0] run_state_led;
   logic first_port_led, second_port_led, exp_led, tbus_green_led, tbus_red_led;
   logic storage_access_led, arm, probe, tg_clr, done;
   logic [23:0] code;
   logic [3:0] tg, fl, fl_prev;
   logic [31:0] rnd = 32'hD82C;
   sli_note_t notes[$];
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;
   sli_top #(.FAST_HALF(4), .SLOW_HALF(8), .GAP(20), .FLASH(3)) sli_top_inst (
      .clk(clk), .rstn(rstn), .run_mode(run_mode),
      .port1_link(port1_link), .port1_act(port1_act),
      .port2_link(port2_link), .port2_act(port2_act),
      .exp_act(exp_act), .tbus_active(tbus_active), .tbus_act(tbus_act),
      .card_busy(card_busy), .err_format(err_format), .err_checksum(err_checksum),
      .err_position(err_position), .run_state_led(run_state_led),
      .first_port_led(first_port_led), .second_port_led(second_port_led),
      .exp_led(exp_led), .tbus_green_led(tbus_green_led), .tbus_red_led(tbus_red_led),
      .storage_access_led(storage_access_led));
   sli_panel sli_panel_inst (.clk(clk), .arm(arm), .red(tbus_red_led), .done(done), .code(code));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic cmp(string what, logic [23:0] e, logic [23:0] s);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic cmp_level(logic [23:0] e, logic [23:0] s);
      cmp("level LEDs", e, s);
   endtask
   task automatic cmp_flash(logic [23:0] e, logic [23:0] s);
      cmp("flashing LEDs", e, s);
   endtask
   task automatic cmp_code(logic [23:0] e, logic [23:0] s);
      cmp("blink code", e, s);
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic note(logic [1:0] k, logic [23:0] v);
      notes.push_back({k, v});
      probe <= 1'b1;
      @(posedge clk);
      probe <= 1'b0;
   endtask
   task automatic flash(logic [3:0] e);
      repeat (20) @(posedge clk);
      tg_clr <= 1'b1;
      @(posedge clk);
      tg_clr <= 1'b0;
      repeat (40) @(posedge clk);
      note(2'h1, {20'h0, e});
   endtask
   task automatic blink(logic f, logic c, logic [7:0] pos, logic [3:0] k, logic [7:0] a);
      notes.push_back({2'h2, 8'(sli_pkg::FAST_PULSES), 4'h0, k, a});
      notes.push_back({2'h2, 8'(sli_pkg::FAST_PULSES), 4'h0, k, a});
      arm <= 1'b1;
      err_format <= f;
      err_checksum <= c;
      err_position <= pos;
      while (notes.size() != 0) @(posedge clk);
      {arm, err_format, err_checksum} <= 3'h0;
      // Let the running sequence and its gap end before the eye is armed again
      repeat (1000) @(posedge clk);
   endtask
   // ****************************************
   // Stimulus
   // ****************************************
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end
   initial begin
      {rstn, port1_link, port1_act, port2_link, port2_act, exp_act} = 6'h00;
      {tbus_active, tbus_act, card_busy, err_format, err_checksum} = 5'h00;
      {run_mode, err_position, arm, probe, tg_clr} = 13'h0000;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 16; i++) begin
         rnd = xs(rnd);
         run_mode <= (i < 4) ? 2'(i) : rnd[1:0];
         port1_link <= rnd[2];
         port2_link <= rnd[3];
         card_busy <= rnd[4];
         repeat (6) @(posedge clk);
         note(2'h0, {16'h0, run_mode == 2'h1, run_mode == 2'h2, run_mode == 2'h3,
                     port1_link, port2_link, card_busy, 2'h0});
      end
      {port1_link, port2_link, port1_act, exp_act, tbus_active, tbus_act} <= 6'h3F;
      flash(4'hD);
      {port1_act, exp_act, tbus_act, port2_act} <= 4'h1;
      flash(4'h2);
      port2_act <= 1'b0;
      flash(4'h0);
      rnd = xs(rnd);
      blink(1'b1, 1'b0, {4'h0, rnd[3:0] | 4'h1}, sli_pkg::ERR_FORMAT, {4'h0, rnd[3:0] | 4'h1});
      blink(1'b0, 1'b1, 8'h5A, sli_pkg::ERR_CHECKSUM, sli_pkg::ARG_NONE);
      blink(1'b1, 1'b1, 8'h03, sli_pkg::ERR_FORMAT, 8'h03);
      give_verdict();
   end
   // ****************************************
   // Monitor
   // ****************************************
   always @(negedge clk) begin
      sli_note_t n;
      fl = {exp_led, first_port_led, second_port_led, tbus_green_led};
      tg = tg_clr ? 4'h0 : (tg | (fl ^ fl_prev));
      fl_prev = fl;
      if (probe === 1'b1 || done === 1'b1) begin
         n = (notes.size() != 0) ? notes.pop_front() : sli_note_t'(26'h3FFFFFF);
         if (done === 1'b1) cmp_code(n.v, code);
         else if (n.kind == 2'h1) cmp_flash(n.v, {20'h0, tg});
         else cmp_level(n.v, {16'h0, run_state_led, first_port_led, second_port_led,
                              storage_access_led, tbus_green_led, tbus_red_led});
      end
   end
endmodule
